// ===== rtl/prt_pkg.sv
// Package for the PWM reload timer and tick unit: register map, field positions, carriers
package prt_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_DUTY_CH1   = 6'h14;
  localparam logic [5:0] IDX_DUTY_CH0   = 6'h15;
  localparam logic [5:0] IDX_PWM_CTRL   = 6'h16;
  localparam logic [5:0] IDX_TMR_CSR    = 6'h17;
  localparam logic [5:0] IDX_LIVE_COUNT = 6'h18;
  localparam logic [5:0] IDX_RELOAD     = 6'h19;
  localparam logic [5:0] IDX_CAP_CSR    = 6'h1A;
  localparam logic [5:0] IDX_CAP_CH1    = 6'h1B;
  localparam logic [5:0] IDX_CAP_CH2    = 6'h1C;
  localparam logic [5:0] IDX_TICK_COUNT = 6'h36;
  localparam logic [5:0] IDX_TICK_CSR   = 6'h37;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CSR_EXT_CLK  = 7;
  localparam int CSR_DIV_LSB  = 4;
  localparam int CSR_RUN      = 3;
  localparam int CSR_FORCE    = 2;
  localparam int CSR_WRAP_IE  = 1;
  localparam int CSR_WRAP     = 0;
  localparam int PWM_OE_LSB   = 4;
  localparam int PWM_POL_LSB  = 0;
  localparam int CAP_EDGE_LSB = 4;
  localparam int CAP_IE_LSB   = 2;
  localparam int CAP_FLAG_LSB = 0;
  localparam int TCK_CHAIN    = 6;
  localparam int TCK_WRAP     = 5;
  localparam int TCK_IE       = 4;
  localparam int TCK_RUN      = 3;
  localparam int TCK_DIV_LSB  = 0;

  // ----------------------------------------------------------------
  // Writable bit masks and constants
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_TMR_CSR  = 8'hFA;
  localparam logic [7:0] MASK_PWM_CTRL = 8'h33;
  localparam logic [7:0] MASK_CAP_CSR  = 8'h3C;
  localparam logic [7:0] MASK_TICK_CSR = 8'h5F;
  localparam logic [7:0] RESET_BYTE    = 8'h00;
  localparam logic [7:0] COUNT_TOP     = 8'hFF;
  localparam logic [7:0] DUTY_ZERO     = 8'h00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } prt_apb_req_type;

  typedef struct packed {
    logic [7:0]      tmr_csr;
    logic [7:0]      count;
    logic [7:0]      reload;
    logic [6:0]      presc;
    logic            ext_d;
    logic [1:0][7:0] duty;
    logic [1:0][7:0] shadow;
    logic [7:0]      pwm_ctrl;
    logic [7:0]      cap_csr;
    logic [1:0][7:0] cap_val;
    logic [1:0]      cap_d;
    logic [7:0]      tick;
    logic [7:0]      tick_csr;
    logic [7:0]      tick_presc;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
    logic [1:0]      pwm;
    logic [1:0]      pwm_oe_n;
    logic            wrap_irq;
    logic [1:0]      cap_irq;
    logic            tick_irq;
  } prt_state_type;

endpackage

// ===== rtl/prt_timer.sv
// PWM auto-reload timer with input capture and a chainable tick unit, APB slave

// How it works
// R1: Prescaler input is the system clock, or rising edges of ext_clk when selected.
// R2: Counter advances once per 2^divider prescaler input ticks.
// R3: Run bit low freezes prescaler and counter; high lets counter advance.
// R4: Force reload reads zero; writing one loads reload value and clears prescaler.
// R5: Wrap interrupt follows wrap flag only while wrap interrupt enable is set.
// R6: Wrap flag sets when counter passes FFh; reading timer status clears it.
// R7: Live count port reads and writes the running counter at any time.
// R8: Overflow reloads the counter and starts each PWM output period.
// R9: Each PWM pin is driven only while its own enable bit is set.
// R10: Polarity zero: output high while count at or below shadow; one inverts.
// R11: Polarity change reverses the PWM output immediately.
// R12: Duty FFh holds output at 0; duty 00h holds it at 1.
// R13: Shadow sets second edge per channel; overflow sets common first edge.
// R14: Capture edge select zero picks falling edge, one picks rising edge.
// R15: Capture interrupt of each channel gated by its own enable bit.
// R16: Capture sets its flag; reading capture status clears flags; top bits zero.
// R17: Capture event latches the counter into that channel's capture value.
// R18: Reset clears every register except pwm_oe_n, which is set to 11: system clock selected, counter stopped.
// R19: Tick run starts tick counting from its current value at divider rate.
// R20: Tick counter roll from FFh to 00h sets tick flag, interrupt if enabled.
// R21: Software may write the tick count any time; counting continues from it.
// R22: Chain mode makes tick count the high byte of a 16-bit counter.
// R23: Overflow copies every duty value into its compare shadow.
// R24: Captured channel keeps its value until capture status is read.
// R25: Tick divider divides by 2^(field+1), 2 to 256.
// R26: Tick run low freezes tick counter and holds its prescaler reset.
// R27: In chain mode tick count steps once per reload-timer overflow.
module prt_timer
  import prt_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Timer pins
  input  wire logic        ext_clk,
  input  wire logic [1:0]  cap_in,
  output logic [1:0]       pwm_out,
  output logic [1:0]       pwm_oe_n,
  // Interrupt requests
  output logic             wrap_irq,
  output logic [1:0]       cap_irq,
  output logic             tick_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  prt_state_type   s_r;
  prt_state_type   s_nxt;
  prt_apb_req_type req;

  logic [5:0] idx;
  logic       hit;
  logic [7:0] rd_val;
  logic       setup_ph;
  logic       done;
  logic       wr_done;
  logic       rd_done;
  logic       in_tick;
  logic [6:0] div_mask;
  logic       cnt_tick;
  logic       wrap_ev;
  logic [1:0] cap_ev;
  logic [1:0] cap_clr;
  logic [7:0] tick_mask;
  logic       tick_step;
  logic       tick_wrap;
  logic [1:0] lvl;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt    = s_r;
    idx      = req.paddr[7:2];
    setup_ph = req.psel & ~req.penable;
    done     = req.psel & req.penable & s_r.pready;
    wr_done  = done & req.pwrite;
    rd_done  = done & ~req.pwrite;

    // Read mux, sampled in the setup cycle so the answer comes from a flop
    hit    = (req.paddr[1:0] == 2'b00);
    rd_val = RESET_BYTE;
    unique case (idx)
      IDX_DUTY_CH1:   rd_val = s_r.duty[1];
      IDX_DUTY_CH0:   rd_val = s_r.duty[0];
      IDX_PWM_CTRL:   rd_val = s_r.pwm_ctrl;
      IDX_TMR_CSR:    rd_val = s_r.tmr_csr;  // R4
      IDX_LIVE_COUNT: rd_val = s_r.count;    // R7
      IDX_RELOAD:     rd_val = s_r.reload;
      IDX_CAP_CSR:    rd_val = s_r.cap_csr;  // R16
      IDX_CAP_CH1:    rd_val = s_r.cap_val[0];
      IDX_CAP_CH2:    rd_val = s_r.cap_val[1];
      IDX_TICK_COUNT: rd_val = s_r.tick;
      IDX_TICK_CSR:   rd_val = s_r.tick_csr;
      default:        hit    = 1'b0;
    endcase

    s_nxt.pready  = setup_ph;
    s_nxt.pslverr = setup_ph & ~hit;
    if (setup_ph) begin
      s_nxt.prdata = {24'h000000, hit ? rd_val : RESET_BYTE};
    end

    // Reload timer prescaler and counter
    s_nxt.ext_d = ext_clk;
    in_tick  = s_r.tmr_csr[CSR_EXT_CLK] ? (ext_clk & ~s_r.ext_d) : 1'b1;  // R1
    div_mask = 7'((8'h01 << s_r.tmr_csr[CSR_DIV_LSB +: 3]) - 8'h01);
    cnt_tick = s_r.tmr_csr[CSR_RUN] & in_tick & ((s_r.presc & div_mask) == div_mask);  // R2 R3
    wrap_ev  = cnt_tick & (s_r.count == COUNT_TOP);
    if (s_r.tmr_csr[CSR_RUN] & in_tick) begin
      s_nxt.presc = s_r.presc + 7'h01;  // R3
    end
    if (cnt_tick) begin
      s_nxt.count = wrap_ev ? s_r.reload : s_r.count + 8'h01;  // R8
    end
    if (wrap_ev) begin
      s_nxt.shadow = s_r.duty;  // R23 R13
    end

    // Tick unit
    tick_mask = 8'((9'h002 << s_r.tick_csr[TCK_DIV_LSB +: 3]) - 9'h001);  // R25
    if (s_r.tick_csr[TCK_CHAIN]) begin
      tick_step = s_r.tick_csr[TCK_RUN] & wrap_ev;  // R22 R27
    end else begin
      tick_step = s_r.tick_csr[TCK_RUN] & ((s_r.tick_presc & tick_mask) == tick_mask);  // R19
    end
    tick_wrap = tick_step & (s_r.tick == COUNT_TOP);
    if (s_r.tick_csr[TCK_RUN] & ~s_r.tick_csr[TCK_CHAIN]) begin
      s_nxt.tick_presc = s_r.tick_presc + 8'h01;
    end else begin
      s_nxt.tick_presc = RESET_BYTE;  // R26
    end
    if (tick_step) begin
      s_nxt.tick = s_r.tick + 8'h01;  // R19
    end

    // Register writes take effect at the completing edge and win over counting
    if (wr_done & hit) begin
      unique case (idx)
        IDX_DUTY_CH1:   s_nxt.duty[1] = req.pwdata[7:0];
        IDX_DUTY_CH0:   s_nxt.duty[0] = req.pwdata[7:0];
        IDX_PWM_CTRL:   s_nxt.pwm_ctrl = req.pwdata[7:0] & MASK_PWM_CTRL;
        IDX_TMR_CSR: begin
          s_nxt.tmr_csr = (s_r.tmr_csr & ~MASK_TMR_CSR) | (req.pwdata[7:0] & MASK_TMR_CSR);
          if (req.pwdata[CSR_FORCE]) begin
            s_nxt.count = s_r.reload;  // R4
            s_nxt.presc = 7'h00;       // R4
          end
        end
        IDX_LIVE_COUNT: begin
          s_nxt.count = req.pwdata[7:0];  // R7
          s_nxt.presc = 7'h00;
        end
        IDX_RELOAD:     s_nxt.reload = req.pwdata[7:0];
        IDX_CAP_CSR:    s_nxt.cap_csr = (s_r.cap_csr & ~MASK_CAP_CSR) | (req.pwdata[7:0] & MASK_CAP_CSR);
        IDX_TICK_COUNT: s_nxt.tick = req.pwdata[7:0];  // R21
        IDX_TICK_CSR:   s_nxt.tick_csr = (s_r.tick_csr & ~MASK_TICK_CSR) | (req.pwdata[7:0] & MASK_TICK_CSR);
        default:        s_nxt.duty = s_r.duty;
      endcase
    end

    // Flags: a read clears only what it returned, a new event in the same cycle wins
    s_nxt.tmr_csr[CSR_WRAP] = (s_r.tmr_csr[CSR_WRAP]
                              & ~(rd_done & (idx == IDX_TMR_CSR) & s_r.prdata[CSR_WRAP])) | wrap_ev;  // R6
    s_nxt.tick_csr[TCK_WRAP] = (s_r.tick_csr[TCK_WRAP]
                               & ~(rd_done & (idx == IDX_TICK_CSR) & s_r.prdata[TCK_WRAP])) | tick_wrap;  // R20

    // Input capture, one pass per channel
    s_nxt.cap_d = cap_in;
    for (int i = 0; i < 2; i++) begin
      cap_ev[i]  = s_r.cap_csr[CAP_EDGE_LSB + i] ? (cap_in[i] & ~s_r.cap_d[i])
                                                 : (~cap_in[i] & s_r.cap_d[i]);  // R14
      cap_clr[i] = rd_done & (idx == IDX_CAP_CSR) & s_r.prdata[CAP_FLAG_LSB + i];  // R16
      if (cap_ev[i] & ~s_r.cap_csr[CAP_FLAG_LSB + i]) begin
        s_nxt.cap_val[i] = s_r.count;  // R17 R24
      end
      s_nxt.cap_csr[CAP_FLAG_LSB + i] = (s_r.cap_csr[CAP_FLAG_LSB + i] & ~cap_clr[i]) | cap_ev[i];  // R16
      s_nxt.cap_irq[i] = s_nxt.cap_csr[CAP_FLAG_LSB + i] & s_nxt.cap_csr[CAP_IE_LSB + i];  // R15
    end

    // PWM outputs, taken from the next count so the pins do not lag a cycle
    for (int i = 0; i < 2; i++) begin
      if (s_nxt.shadow[i] == COUNT_TOP) begin
        lvl[i] = 1'b0;  // R12
      end else if (s_nxt.shadow[i] == DUTY_ZERO) begin
        lvl[i] = 1'b1;  // R12
      end else begin
        lvl[i] = (s_nxt.count <= s_nxt.shadow[i]);  // R10 R13
      end
      // Polarity acts on the level directly, so a flip shows on the edge that completes the write
      s_nxt.pwm[i]      = s_nxt.pwm_ctrl[PWM_OE_LSB + i]
                          & (lvl[i] ^ s_nxt.pwm_ctrl[PWM_POL_LSB + i]);  // R9 R11
      s_nxt.pwm_oe_n[i] = ~s_nxt.pwm_ctrl[PWM_OE_LSB + i];  // R9
    end

    s_nxt.wrap_irq = s_nxt.tmr_csr[CSR_WRAP] & s_nxt.tmr_csr[CSR_WRAP_IE];   // R5
    s_nxt.tick_irq = s_nxt.tick_csr[TCK_WRAP] & s_nxt.tick_csr[TCK_IE];      // R20
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r          <= '0;     // R18
      s_r.pwm_oe_n <= 2'b11;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata   = s_r.prdata;
  assign pready   = s_r.pready;
  assign pslverr  = s_r.pslverr;
  assign pwm_out  = s_r.pwm;
  assign pwm_oe_n = s_r.pwm_oe_n;
  assign wrap_irq = s_r.wrap_irq;
  assign cap_irq  = s_r.cap_irq;
  assign tick_irq = s_r.tick_irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence cap0_edge_s;
    cap_ev[0] && !s_r.cap_csr[CAP_FLAG_LSB];
  endsequence

  sequence cap0_latched_s;
    s_r.cap_csr[CAP_FLAG_LSB] && (s_r.cap_val[0] == $past(s_r.count));
  endsequence

  force_reads_zero_a: assert property ( // R4
    setup_ph && !req.pwrite && idx == IDX_TMR_CSR |=> !prdata[CSR_FORCE])
    else $error("force reload bit read back as one");

  force_loads_a: assert property ( // R4
    wr_done && idx == IDX_TMR_CSR && req.pwdata[CSR_FORCE] |=> s_r.count == $past(s_r.reload) && s_r.presc == 7'h00)
    else $error("force reload did not load counter");

  stop_freezes_a: assert property ( // R3
    !s_r.tmr_csr[CSR_RUN] && !wr_done |=> $stable(s_r.count) && $stable(s_r.presc))
    else $error("counter moved while stopped");

  wrap_reloads_a: assert property ( // R6
    wrap_ev && !wr_done |=> s_r.tmr_csr[CSR_WRAP] && s_r.count == $past(s_r.reload))
    else $error("overflow did not reload and flag");

  shadow_copy_a: assert property ( // R23
    wrap_ev |=> s_r.shadow == $past(s_r.duty))
    else $error("shadow not loaded at overflow");

  wrap_irq_gate_a: assert property ( // R5
    wrap_irq |-> s_r.tmr_csr[CSR_WRAP_IE] && s_r.tmr_csr[CSR_WRAP])
    else $error("wrap interrupt without enable");

  pwm_disabled_a: assert property ( // R9
    !s_r.pwm_ctrl[PWM_OE_LSB] |-> pwm_oe_n[0] && !pwm_out[0])
    else $error("disabled channel drives its pin");

  duty_full_a: assert property ( // R12
    s_r.pwm_ctrl[PWM_OE_LSB] && !s_r.pwm_ctrl[PWM_POL_LSB] && s_r.shadow[0] == COUNT_TOP |-> !pwm_out[0])
    else $error("full duty did not hold output low");

  capture_latch_a: assert property ( // R17
    cap0_edge_s |=> cap0_latched_s)
    else $error("capture did not latch counter");

  capture_block_a: assert property ( // R24
    s_r.cap_csr[CAP_FLAG_LSB] && !cap_clr[0] |=> $stable(s_r.cap_val[0]))
    else $error("capture value changed while flagged");

  tick_roll_a: assert property ( // R20
    tick_wrap && !wr_done |=> s_r.tick_csr[TCK_WRAP] && s_r.tick == 8'h00)
    else $error("tick roll did not set flag");

  tick_stop_a: assert property ( // R26
    !s_r.tick_csr[TCK_RUN] && !wr_done |=> $stable(s_r.tick) && s_r.tick_presc == 8'h00)
    else $error("tick unit moved while stopped");

  // ----------------------------------------------------------------
  // Further checks: second channel, PWM levels, writes and clears
  // ----------------------------------------------------------------
  sequence cap1_edge_s;
    cap_ev[1] && !s_r.cap_csr[CAP_FLAG_LSB + 1];
  endsequence

  sequence cap1_latched_s;
    s_r.cap_csr[CAP_FLAG_LSB + 1] && (s_r.cap_val[1] == $past(s_r.count));
  endsequence

  capture1_latch_a: assert property ( // R17
    cap1_edge_s |=> cap1_latched_s)
    else $error("second capture did not latch counter");

  capture_clear_a: assert property ( // R16
    cap_clr[0] && !cap_ev[0] |=> !s_r.cap_csr[CAP_FLAG_LSB])
    else $error("capture flag survived its read");

  cap_top_zero_a: assert property ( // R16
    setup_ph && !req.pwrite && idx == IDX_CAP_CSR |=> prdata[7:6] == 2'b00)
    else $error("capture status top bits not zero");

  cap_irq_gate_a: assert property ( // R15
    cap_irq[0] |-> s_r.cap_csr[CAP_IE_LSB] && s_r.cap_csr[CAP_FLAG_LSB])
    else $error("capture interrupt without enable");

  pwm1_disabled_a: assert property ( // R9
    !s_r.pwm_ctrl[PWM_OE_LSB + 1] |-> pwm_oe_n[1] && !pwm_out[1])
    else $error("disabled second channel drives its pin");

  duty_zero_a: assert property ( // R12
    s_r.pwm_ctrl[PWM_OE_LSB] && !s_r.pwm_ctrl[PWM_POL_LSB] && s_r.shadow[0] == DUTY_ZERO |-> pwm_out[0])
    else $error("zero duty did not hold output high");

  pwm_compare_a: assert property ( // R10
    s_r.pwm_ctrl[PWM_OE_LSB] && !s_r.pwm_ctrl[PWM_POL_LSB] && s_r.shadow[0] != COUNT_TOP
    && s_r.shadow[0] != DUTY_ZERO |-> pwm_out[0] == (s_r.count <= s_r.shadow[0]))
    else $error("output level does not follow compare");

  pwm_polarity_a: assert property ( // R11
    s_r.pwm_ctrl[PWM_OE_LSB] && s_r.pwm_ctrl[PWM_POL_LSB] && s_r.shadow[0] != COUNT_TOP
    && s_r.shadow[0] != DUTY_ZERO |-> pwm_out[0] == (s_r.count > s_r.shadow[0]))
    else $error("inverted polarity level wrong");

  live_write_a: assert property ( // R7
    wr_done && idx == IDX_LIVE_COUNT |=> s_r.count == $past(req.pwdata[7:0]) && s_r.presc == 7'h00)
    else $error("live count write did not load counter");

  reload_write_a: assert property ( // R8
    wr_done && idx == IDX_RELOAD |=> s_r.reload == $past(req.pwdata[7:0]))
    else $error("reload value write lost");

  wrap_clear_a: assert property ( // R6
    rd_done && idx == IDX_TMR_CSR && s_r.prdata[CSR_WRAP] && !wrap_ev |=> !s_r.tmr_csr[CSR_WRAP])
    else $error("wrap flag survived its read");

  ext_select_a: assert property ( // R1
    s_r.tmr_csr[CSR_EXT_CLK] && s_r.tmr_csr[CSR_RUN] && !(ext_clk && !s_r.ext_d) && !wr_done
    |=> $stable(s_r.presc) && $stable(s_r.count))
    else $error("prescaler moved without external edge");

  tick_chain_a: assert property ( // R27
    s_r.tick_csr[TCK_CHAIN] && s_r.tick_csr[TCK_RUN] && wrap_ev && !wr_done
    |=> s_r.tick == $past(s_r.tick) + 8'h01)
    else $error("chained tick did not step on overflow");

  tick_write_a: assert property ( // R21
    wr_done && idx == IDX_TICK_COUNT |=> s_r.tick == $past(req.pwdata[7:0]))
    else $error("tick count write lost");

  tick_irq_gate_a: assert property ( // R20
    tick_irq |-> s_r.tick_csr[TCK_IE] && s_r.tick_csr[TCK_WRAP])
    else $error("tick interrupt without enable");

endmodule

// ===== tb/prt_timer_bench.sv
// Self-checking bench for the PWM reload timer with tick unit
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end

module prt_timer_bench
  import prt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_clk;
  logic [1:0]  cap_in;
  logic [1:0]  pwm_out;
  logic [1:0]  pwm_oe_n;
  logic        wrap_irq;
  logic [1:0]  cap_irq;
  logic        tick_irq;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  df;
  int          n_fail;
  int          compares;

  prt_timer i_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clk(ext_clk), .cap_in(cap_in), .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n),
    .wrap_irq(wrap_irq), .cap_irq(cap_irq), .tick_irq(tick_irq));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic results();
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Two idle edges after each transfer so registered side effects have landed
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] wd);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      n_fail++;
      results();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] v);
    xfer(1'b1, idx, v);
  endtask

  task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    `CHK(rd, {24'h000000, exp})
  endtask

  // Snapshots are span cycles apart, so a span that is a multiple of the divider is phase-free
  task automatic span_diff(input logic [5:0] idx, input int span, output logic [7:0] d);
    logic [7:0] a;
    xfer(1'b0, idx, 8'h00);
    a = rd[7:0];
    repeat (span - 4) @(posedge clk);
    xfer(1'b0, idx, 8'h00);
    d = rd[7:0] - a;
  endtask

  task automatic wait_irq(input logic tick);
    int n;
    for (n = 0; n < 40 && (tick ? tick_irq : wrap_irq) !== 1'b1; n++) @(posedge clk);
    if (n == 40) begin
      n_fail++;
      results();
    end
  endtask

  task automatic ovf_pulse();
    wr(IDX_LIVE_COUNT, 8'hFF);
    wr(IDX_TMR_CSR, 8'h08);
    wr(IDX_TMR_CSR, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    n_fail = 0;
    compares = 0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    ext_clk = 1'b0;
    cap_in = 2'b01;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    `CHK(pwm_oe_n, 2'b11)
    `CHK({wrap_irq, cap_irq, tick_irq, pwm_out}, 6'h00)
    for (int i = 'h14; i <= 'h1C; i++) rdc(6'(i), 8'h00);
    rdc(IDX_TICK_COUNT, 8'h00);
    rdc(IDX_TICK_CSR, 8'h00);
    xfer(1'b0, 6'h00, 8'h00);
    `CHK({err, rd}, {1'b1, 32'h00000000})
    wr(IDX_CAP_CH1, 8'hAA);
    rdc(IDX_CAP_CH1, 8'h00);
    wr(IDX_PWM_CTRL, 8'hFF);
    rdc(IDX_PWM_CTRL, 8'h33);
    wr(IDX_CAP_CSR, 8'hFF);
    rdc(IDX_CAP_CSR, 8'h3C);
    wr(IDX_PWM_CTRL, 8'h00);
    wr(IDX_CAP_CSR, 8'h00);
    // Counter divider, run, external clock, force reload
    for (int k = 0; k < 8; k++) begin
      wr(IDX_TMR_CSR, {1'b0, 3'(k), 4'h8});
      span_diff(IDX_LIVE_COUNT, 8 << k, df);
      `CHK(df, 8'h08)
    end
    wr(IDX_TMR_CSR, 8'h00);
    span_diff(IDX_LIVE_COUNT, 64, df);
    `CHK(df, 8'h00)
    wr(IDX_TMR_CSR, 8'h88);
    xfer(1'b0, IDX_LIVE_COUNT, 8'h00);
    df = rd[7:0];
    repeat (5) begin
      ext_clk <= 1'b1;
      @(posedge clk);
      ext_clk <= 1'b0;
      repeat (2) @(posedge clk);
    end
    xfer(1'b0, IDX_LIVE_COUNT, 8'h00);
    `CHK(8'(rd[7:0] - df), 8'h05)
    wr(IDX_TMR_CSR, 8'h00);
    wr(IDX_RELOAD, 8'h37);
    wr(IDX_TMR_CSR, 8'h04);
    rdc(IDX_LIVE_COUNT, 8'h37);
    rdc(IDX_TMR_CSR, 8'h00);
    // Wrap flag, interrupt gating and reload
    wr(IDX_RELOAD, 8'hF0);
    wr(IDX_LIVE_COUNT, 8'hFE);
    wr(IDX_TMR_CSR, 8'h0A);
    wait_irq(1'b0);
    wr(IDX_TMR_CSR, 8'h02);
    rdc(IDX_TMR_CSR, 8'h03);
    rdc(IDX_TMR_CSR, 8'h02);
    `CHK(wrap_irq, 1'b0)
    xfer(1'b0, IDX_LIVE_COUNT, 8'h00);
    `CHK(rd[7:0] >= 8'hF0, 1'b1)
    wr(IDX_LIVE_COUNT, 8'hFE);
    wr(IDX_TMR_CSR, 8'h08);
    repeat (20) @(posedge clk);
    `CHK(wrap_irq, 1'b0)
    wr(IDX_TMR_CSR, 8'h00);
    rdc(IDX_TMR_CSR, 8'h01);
    // PWM outputs
    wr(IDX_RELOAD, 8'h00);
    wr(IDX_DUTY_CH0, 8'h80);
    wr(IDX_DUTY_CH1, 8'hFF);
    wr(IDX_PWM_CTRL, 8'h30);
    ovf_pulse();
    `CHK(pwm_oe_n, 2'b00)
    `CHK(pwm_out, 2'b01)
    wr(IDX_PWM_CTRL, 8'h31);
    `CHK(pwm_out, 2'b00)
    wr(IDX_PWM_CTRL, 8'h30);
    wr(IDX_LIVE_COUNT, 8'h90);
    `CHK(pwm_out[0], 1'b0)
    wr(IDX_DUTY_CH1, 8'hA0);
    `CHK(pwm_out[1], 1'b0)
    ovf_pulse();
    `CHK(pwm_out, 2'b11)
    wr(IDX_DUTY_CH0, 8'h00);
    ovf_pulse();
    wr(IDX_LIVE_COUNT, 8'h90);
    `CHK(pwm_out[0], 1'b1)
    wr(IDX_PWM_CTRL, 8'h20);
    `CHK({pwm_oe_n, pwm_out[0]}, 3'b010)
    // Input capture
    wr(IDX_LIVE_COUNT, 8'h42);
    wr(IDX_CAP_CSR, 8'h2C);
    cap_in <= 2'b10;
    repeat (4) @(posedge clk);
    `CHK(cap_irq, 2'b11)
    rdc(IDX_CAP_CH1, 8'h42);
    rdc(IDX_CAP_CH2, 8'h42);
    wr(IDX_LIVE_COUNT, 8'h55);
    cap_in <= 2'b01;
    repeat (2) @(posedge clk);
    cap_in <= 2'b00;
    repeat (2) @(posedge clk);
    rdc(IDX_CAP_CH1, 8'h42);
    rdc(IDX_CAP_CSR, 8'h2F);
    rdc(IDX_CAP_CSR, 8'h2C);
    `CHK(cap_irq, 2'b00)
    wr(IDX_CAP_CSR, 8'h24);
    cap_in <= 2'b11;
    repeat (4) @(posedge clk);
    `CHK(cap_irq, 2'b00)
    rdc(IDX_CAP_CSR, 8'h26);
    rdc(IDX_CAP_CH2, 8'h55);
    cap_in <= 2'b01;
    repeat (4) @(posedge clk);
    rdc(IDX_CAP_CSR, 8'h24);
    // Tick unit
    for (int k = 0; k < 8; k++) begin
      wr(IDX_TICK_CSR, {5'b00001, 3'(k)});
      span_diff(IDX_TICK_COUNT, 4 << (k + 1), df);
      `CHK(df, 8'h04)
    end
    wr(IDX_TICK_CSR, 8'h00);
    span_diff(IDX_TICK_COUNT, 64, df);
    `CHK(df, 8'h00)
    wr(IDX_TICK_COUNT, 8'hFE);
    wr(IDX_TICK_CSR, 8'h18);
    wait_irq(1'b1);
    wr(IDX_TICK_CSR, 8'h10);
    rdc(IDX_TICK_CSR, 8'h30);
    rdc(IDX_TICK_CSR, 8'h10);
    `CHK(tick_irq, 1'b0)
    wr(IDX_TICK_CSR, 8'h48);
    wr(IDX_TMR_CSR, 8'h08);
    span_diff(IDX_TICK_COUNT, 512, df);
    `CHK(df, 8'h02)
    results();
  end
endmodule
